// ===== design/csp_clock_ctrl.v
/*
 * csp_clock_ctrl.v: clock source decode, start-up sequencing, PLL
 * control and gating of the core, I/O, flash and converter clocks.
 * Assumes a free-running CLK; fuse, oscillator, watchdog, lock and
 * interrupt pins are asynchronous and are synchronised here.
 */
// Overview of operation
// - Decode four fuse bits into clock source
// - Port B bits 4/5 become clock pins
// - Fuse read one means unprogrammed
// - Wake start-up counts selected source clock
// - Reset delay timed by watchdog oscillator
// - External clock start-up per fuse setting
// - PLL multiplies reference by eight
// - PLL enabled by fuse 0001 and bit
// - Power-down and standby stop RC oscillator, PLL
// - Low-speed bit halves PLL reference
// - Low-speed set refused in PLL mode
// - Locked flag set on PLL lock
// - PLL mode uses PLL divided by four
// - PLL mode start-up times per fuse
// - Fast clock selectable for timer one
// - Converter clock gated separately
// - Flash clock gated with core clock
// - External interrupts seen while I/O halted
`timescale 1ns/100ps
`default_nettype none
`include "csp_regs.vh"

module csp_clock_ctrl #(
   parameter        EXT_INTS = 2,
   parameter [13:0] WD_SHORT = `CSP_WD_4MS,
   parameter [13:0] WD_LONG  = `CSP_WD_64MS,
   parameter [16:0] CK_1K    = `CSP_CK_1K,
   parameter [16:0] CK_16K   = `CSP_CK_16K,
   parameter [16:0] CK_32K   = `CSP_CK_32K
) (
   input  wire                CLK,
   input  wire                RESET_N,
   input  wire [2:0]          ADDR,
   input  wire [7:0]          WR_DATA,
   input  wire                WR_STB,
   input  wire                RD_STB,
   output reg  [7:0]          RD_DATA,
   input  wire [3:0]          FUSE_CLK_SEL,
   input  wire [1:0]          FUSE_STARTUP,
   input  wire                SRC_CLK_IN,
   input  wire                WDT_OSC_IN,
   input  wire                PLL_LOCK_IN,
   input  wire [EXT_INTS-1:0] EXT_INT_N,
   input  wire                SLEEP_CMD,
   input  wire                WAKE_REQ,
   output reg                 CORE_CLK_EN,
   output reg                 IO_CLK_EN,
   output reg                 FLASH_CLK_EN,
   output reg                 CONV_CLK_EN,
   output reg                 RC_OSC_EN,
   output reg                 PLL_EN,
   output reg                 PLL_REF_HALF,
   output reg                 PLL_LOCKED,
   output reg  [2:0]          SYS_SRC,
   output reg  [1:0]          XTAL_RANGE,
   output reg                 SYS_PLL_DIV4,
   output reg                 T1_FAST_CLK_SEL,
   output reg                 PB4_CLK_IN_SEL,
   output reg                 PB5_XTAL_OUT_SEL,
   output reg  [7:0]          OSC_TRIM,
   output reg  [6:0]          FAST_CLK_MHZ,
   output reg                 EXT_INT_WAKE
);

   localparam AW    = EXT_INTS + 9;
   localparam I_LCK = EXT_INTS;
   localparam I_WDT = EXT_INTS + 1;
   localparam I_SRC = EXT_INTS + 2;
   localparam I_SUT = EXT_INTS + 3;
   localparam I_SEL = EXT_INTS + 5;

   localparam ST_BOOT  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_RUN   = 2'd2;
   localparam ST_SLEEP = 2'd3;

   // Four-bit fuse decode; raw read values, so 1 is an unprogrammed bit
   function [2:0] src_of;
      input [3:0] sel;
      begin
         casez (sel)
            4'b0000: src_of = `CSP_SRC_EXT;
            4'b0001: src_of = `CSP_SRC_PLL;
            4'b0010: src_of = `CSP_SRC_RC8;
            4'b0011: src_of = `CSP_SRC_RC128;
            4'b01??: src_of = `CSP_SRC_LFXTAL;
            default: src_of = `CSP_SRC_XTAL;
         endcase
      end
   endfunction

   function [16:0] ck_of;
      input [3:0] sel;
      input [1:0] startup_time_fuses;
      input       from_rst;
      begin
         case (src_of(sel))
            `CSP_SRC_PLL:
               ck_of = `CSP_CK_RESET + (startup_time_fuses[0] ? CK_16K : CK_1K);
            `CSP_SRC_LFXTAL:
               ck_of = (startup_time_fuses == 2'b10) ? CK_32K : CK_1K;
            `CSP_SRC_XTAL:
               ck_of = CK_16K;
            default:
               ck_of = from_rst ? `CSP_CK_RESET : `CSP_CK_SLEEP;
         endcase
      end
   endfunction

   function [13:0] wd_of;
      input [3:0] sel;
      input [1:0] startup_time_fuses;
      input       from_rst;
      reg   [13:0] rst_wd;
      begin
         rst_wd = (startup_time_fuses == 2'b00) ? WD_SHORT : WD_LONG;
         case (src_of(sel))
            `CSP_SRC_PLL: begin
               // Power-on adds the short time-out on every setting
               wd_of = (startup_time_fuses[1] ? WD_LONG : WD_SHORT) +
                       (from_rst ? WD_SHORT : 14'h0000);
            end
            `CSP_SRC_LFXTAL, `CSP_SRC_XTAL:
               wd_of = from_rst ? rst_wd : 14'h0000;
            default: begin
               if (!from_rst || startup_time_fuses == 2'b00)
                  wd_of = 14'h0000;
               else if (startup_time_fuses == 2'b01)
                  wd_of = WD_SHORT;
               else
                  wd_of = WD_LONG;
            end
         endcase
      end
   endfunction

   function [6:0] pck_mhz;
      input half;
      begin
         if (half)
            pck_mhz = (`CSP_RC_MHZ >> 1) * `CSP_PLL_MULT;
         else
            pck_mhz = `CSP_RC_MHZ * `CSP_PLL_MULT;
      end
   endfunction

   reg  [AW-1:0] sync1;
   reg  [AW-1:0] sync2;
   reg           src_last;
   reg           wdt_last;
   reg  [1:0]    state;
   reg  [1:0]    next_state;
   reg  [1:0]    boot_cnt;
   reg           tmr_start;
   reg           from_rst;
   reg           pll_bit;
   reg  [2:0]    slp_mode;
   reg  [7:0]    rd_mux;

   wire [AW-1:0] async_in;
   wire [3:0]    fuse_sel;
   wire [1:0]    fuse_sut;
   wire          src_tick;
   wire          wdt_tick;
   wire          ext_req;
   wire          pll_mode;
   wire          deep;
   wire          osc_off;
   wire          idle;
   wire          noise;
   wire          tmr_busy;
   wire          tmr_done;
   wire          next_run;
   wire          next_sleep;
   wire          wr_pllcs;
   wire          boot_end;

   assign async_in = {FUSE_CLK_SEL, FUSE_STARTUP, SRC_CLK_IN,
                      WDT_OSC_IN, PLL_LOCK_IN, EXT_INT_N};

   // Every fuse, oscillator, lock and interrupt pin passes two flops before any logic sees it
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         sync1    <= {{9{1'b0}}, {EXT_INTS{1'b1}}};
         sync2    <= {{9{1'b0}}, {EXT_INTS{1'b1}}};
         src_last <= 1'b0;
         wdt_last <= 1'b0;
      end else begin
         sync1    <= async_in;
         sync2    <= sync1;
         src_last <= sync2[I_SRC];
         wdt_last <= sync2[I_WDT];
      end
   end

   assign fuse_sel = sync2[I_SEL+3:I_SEL];
   assign fuse_sut = sync2[I_SUT+1:I_SUT];
   assign src_tick = sync2[I_SRC] & ~src_last;
   assign wdt_tick = sync2[I_WDT] & ~wdt_last;
   // Level detect on the always-running clock, not on the I/O clock
   assign ext_req  = ~&sync2[EXT_INTS-1:0];
   assign pll_mode = (fuse_sel == `CSP_SEL_PLL);
   assign idle     = (slp_mode == `CSP_SLP_IDLE);
   assign noise    = (slp_mode == `CSP_SLP_NOISE);
   assign osc_off  = (slp_mode == `CSP_SLP_PDOWN) |
                     (slp_mode == `CSP_SLP_STANDBY);
   assign deep     = osc_off | (slp_mode == `CSP_SLP_PSAVE);
   assign wr_pllcs = WR_STB & (ADDR == `CSP_ADDR_PLLCS);
   assign boot_end = (state == ST_BOOT) & (boot_cnt == `CSP_BOOT_WAIT);

   // Start-up timer keeps the clocks gated in ST_START until done
   csp_startup_timer #(
      .CKW (17),
      .WDW (14)
   ) u_timer (
      .clk     (CLK),
      .reset_n (RESET_N),
      .start   (tmr_start),
      .ck_load (ck_of(fuse_sel, fuse_sut, from_rst)),
      .wd_load (wd_of(fuse_sel, fuse_sut, from_rst)),
      .ck_tick (src_tick),
      .wd_tick (wdt_tick),
      .busy    (tmr_busy),
      .done    (tmr_done)
   );

   always @* begin
      next_state = state;
      tmr_start  = 1'b0;
      from_rst   = 1'b0;
      case (state)
         ST_BOOT: begin
            from_rst = 1'b1;
            if (boot_end) begin
               tmr_start  = 1'b1;
               next_state = ST_START;
            end
         end
         ST_START: begin
            if (tmr_done)
               next_state = ST_RUN;
         end
         ST_RUN: begin
            if (SLEEP_CMD)
               next_state = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (ext_req || (WAKE_REQ && !deep)) begin
               if (deep) begin
                  tmr_start  = 1'b1;
                  next_state = ST_START;
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         default: next_state = ST_BOOT;
      endcase
   end

   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         state    <= ST_BOOT;
         boot_cnt <= 2'h0;
      end else begin
         state <= next_state;
         if (state == ST_BOOT)
            boot_cnt <= boot_cnt + 1'b1;
      end
   end

   assign next_run   = (next_state == ST_RUN);
   assign next_sleep = (next_state == ST_SLEEP);

   // Software registers
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         pll_bit         <= 1'b0;
         PLL_REF_HALF    <= 1'b0;
         OSC_TRIM        <= `CSP_TRIM_RST;
         slp_mode        <= `CSP_SLP_RST;
         T1_FAST_CLK_SEL <= 1'b0;
      end else begin
         // PLL mode needs the PLL running from the first instruction
         if (boot_end)
            pll_bit <= pll_mode;
         else if (wr_pllcs)
            pll_bit <= WR_DATA[`CSP_PLLCS_EN];
         if (wr_pllcs)
            PLL_REF_HALF <= WR_DATA[`CSP_PLLCS_LOWSPD] & ~pll_mode;
         if (WR_STB && ADDR == `CSP_ADDR_TRIM)
            OSC_TRIM <= WR_DATA;
         if (WR_STB && ADDR == `CSP_ADDR_SLPCTL) begin
            slp_mode        <= WR_DATA[`CSP_SLP_MODE_MSB:0];
            T1_FAST_CLK_SEL <= WR_DATA[`CSP_SLP_T1FAST];
         end
      end
   end

   // Clock gates and oscillator controls, all from next_state
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         CORE_CLK_EN      <= 1'b0;
         FLASH_CLK_EN     <= 1'b0;
         IO_CLK_EN        <= 1'b0;
         CONV_CLK_EN      <= 1'b0;
         RC_OSC_EN        <= 1'b1;
         PLL_EN           <= 1'b0;
         PLL_LOCKED       <= 1'b0;
         FAST_CLK_MHZ     <= 7'h00;
         EXT_INT_WAKE     <= 1'b0;
      end else begin
         CORE_CLK_EN  <= next_run;
         FLASH_CLK_EN <= next_run;
         IO_CLK_EN    <= next_run | (next_sleep & idle);
         CONV_CLK_EN  <= next_run | (next_sleep & (idle | noise));
         RC_OSC_EN    <= ~(next_sleep & osc_off);
         PLL_EN       <= pll_mode & pll_bit & ~(next_sleep & osc_off);
         // Lock is only meaningful while the loop is powered
         PLL_LOCKED   <= sync2[I_LCK] & PLL_EN;
         FAST_CLK_MHZ <= PLL_EN ? pck_mhz(PLL_REF_HALF) : 7'h00;
         EXT_INT_WAKE <= ext_req;
      end
   end

   // Pins stay general I/O until the synced fuses are valid
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         SYS_SRC          <= `CSP_SRC_EXT;
         XTAL_RANGE       <= 2'h0;
         SYS_PLL_DIV4     <= 1'b0;
         PB4_CLK_IN_SEL   <= 1'b0;
         PB5_XTAL_OUT_SEL <= 1'b0;
      end else if (state != ST_BOOT || boot_cnt[1]) begin
         SYS_SRC          <= src_of(fuse_sel);
         XTAL_RANGE       <= fuse_sel[2:1];
         SYS_PLL_DIV4     <= pll_mode;
         PB4_CLK_IN_SEL   <= (fuse_sel == `CSP_SEL_EXT) |
                             fuse_sel[3] | fuse_sel[2];
         PB5_XTAL_OUT_SEL <= fuse_sel[3] | fuse_sel[2];
      end
   end

   always @* begin
      case (ADDR)
         `CSP_ADDR_PLLCS:
            rd_mux = {PLL_REF_HALF, 5'h00, pll_bit, PLL_LOCKED};
         `CSP_ADDR_TRIM:
            rd_mux = OSC_TRIM;
         `CSP_ADDR_SLPCTL:
            rd_mux = {4'h0, T1_FAST_CLK_SEL, slp_mode};
         `CSP_ADDR_STATUS:
            // Programmed fuse bits read as one here
            rd_mux = {tmr_busy, SYS_SRC, ~fuse_sel};
         `CSP_ADDR_FREQ:
            rd_mux = {1'b0, FAST_CLK_MHZ};
         default:
            rd_mux = 8'h00;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe
   always @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N)
         RD_DATA <= 8'h00;
      else if (RD_STB)
         RD_DATA <= rd_mux;
      else
         RD_DATA <= 8'h00;
   end

endmodule

`default_nettype wire

// ===== shared/csp_regs.vh
/*
 * csp_regs.vh: register offsets, field positions, reset values, fuse
 * codes, sleep-mode codes and start-up counts of the clock control block.
 * Definitions only; included by the clock control module, not by the start-up timer.
 */
`ifndef CSP_REGS_VH
`define CSP_REGS_VH

// Register offsets on the plain register port
`define CSP_ADDR_PLLCS    3'h0
`define CSP_ADDR_TRIM     3'h1
`define CSP_ADDR_SLPCTL   3'h2
`define CSP_ADDR_STATUS   3'h3
`define CSP_ADDR_FREQ     3'h4

// pll_control_status_register fields
`define CSP_PLLCS_LOCK    0
`define CSP_PLLCS_EN      1
`define CSP_PLLCS_LOWSPD  7

// Sleep control fields
`define CSP_SLP_MODE_MSB  2
`define CSP_SLP_T1FAST    3

// Reset values
`define CSP_TRIM_RST      8'h80
`define CSP_SLP_RST       3'h0

// clock_source_select_fuses codes, as read (1 = unprogrammed)
`define CSP_SEL_EXT       4'h0
`define CSP_SEL_PLL       4'h1
`define CSP_SEL_RC8       4'h2
`define CSP_SEL_RC128     4'h3

// Source codes reported on SYS_SRC
`define CSP_SRC_EXT       3'h0
`define CSP_SRC_PLL       3'h1
`define CSP_SRC_RC8       3'h2
`define CSP_SRC_RC128     3'h3
`define CSP_SRC_LFXTAL    3'h4
`define CSP_SRC_XTAL      3'h5

// Sleep modes
`define CSP_SLP_IDLE      3'h0
`define CSP_SLP_NOISE     3'h1
`define CSP_SLP_PDOWN     3'h2
`define CSP_SLP_PSAVE     3'h3
`define CSP_SLP_STANDBY   3'h4

// Start-up counts: source clock, watchdog oscillator and CLK cycles
`define CSP_CK_SLEEP      17'd6
`define CSP_CK_RESET      17'd14
`define CSP_CK_1K         17'd1024
`define CSP_CK_16K        17'd16384
`define CSP_CK_32K        17'd32768
`define CSP_WD_4MS        14'd512
`define CSP_WD_64MS       14'd8192
`define CSP_BOOT_WAIT     2'h3

// PLL figures: reference in MHz and multiplier
`define CSP_RC_MHZ        7'd8
`define CSP_PLL_MULT      7'd8

`endif

// ===== design/csp_startup_timer.v
/*
 * csp_startup_timer.v: two-phase start-up counter. Counts source clock
 * ticks, then watchdog oscillator ticks, then pulses done.
 * Assumes tick inputs are already synchronised one-cycle pulses on clk.
 */
`timescale 1ns/100ps
`default_nettype none

module csp_startup_timer #(
   parameter CKW = 17,
   parameter WDW = 14
) (
   input  wire           clk,
   input  wire           reset_n,
   input  wire           start,
   input  wire [CKW-1:0] ck_load,
   input  wire [WDW-1:0] wd_load,
   input  wire           ck_tick,
   input  wire           wd_tick,
   output reg            busy,
   output reg            done
);

   reg [CKW-1:0] ck_left;
   reg [WDW-1:0] wd_left;

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ck_left <= {CKW{1'b0}};
         wd_left <= {WDW{1'b0}};
         busy    <= 1'b0;
         done    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            ck_left <= ck_load;
            wd_left <= wd_load;
            busy    <= 1'b1;
         end else if (busy) begin
            // Oscillator cycles first, then the real-time part
            if (ck_left != {CKW{1'b0}}) begin
               if (ck_tick)
                  ck_left <= ck_left - 1'b1;
            end else if (wd_left != {WDW{1'b0}}) begin
               if (wd_tick)
                  wd_left <= wd_left - 1'b1;
            end else begin
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== tb/csp_clock_ctrl_assertions.sv
/* csp_clock_ctrl_assertions.sv: port-level checks of clock control.
   Assumes fuses change only while RESET_N is low. */
`timescale 1ns/100ps
`default_nettype none
module csp_clock_ctrl_assertions #(
   parameter EXT_INTS = 2
) (
   input wire logic                CLK,
   input wire logic                RESET_N,
   input wire logic [3:0]          FUSE_CLK_SEL,
   input wire logic [EXT_INTS-1:0] EXT_INT_N,
   input wire logic                CORE_CLK_EN,
   input wire logic                IO_CLK_EN,
   input wire logic                FLASH_CLK_EN,
   input wire logic                CONV_CLK_EN,
   input wire logic                PLL_EN,
   input wire logic                PLL_REF_HALF,
   input wire logic                PLL_LOCKED,
   input wire logic [2:0]          SYS_SRC,
   input wire logic                SYS_PLL_DIV4,
   input wire logic                PB4_CLK_IN_SEL,
   input wire logic                PB5_XTAL_OUT_SEL,
   input wire logic [6:0]          FAST_CLK_MHZ,
   input wire logic                EXT_INT_WAKE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   chk_flash_core: assert property (FLASH_CLK_EN == CORE_CLK_EN)
      else $error("flash enable differs from core enable");
   chk_pll_fuse: assert property (PLL_EN |-> FUSE_CLK_SEL == 4'h1)
      else $error("pll on outside pll fuse code");
   chk_lock_enable: assert property (PLL_LOCKED |-> $past(PLL_EN))
      else $error("locked flag without pll enable");
   chk_half_refused: assert property (SYS_PLL_DIV4 |-> !PLL_REF_HALF)
      else $error("low speed set while pll drives system");
   chk_div4_src: assert property (SYS_PLL_DIV4 |-> SYS_SRC == 3'h1)
      else $error("pll divide by four in wrong mode");
   chk_pin_roles: assert property (PB5_XTAL_OUT_SEL |->
      PB4_CLK_IN_SEL && SYS_SRC >= 3'h4)
      else $error("crystal output pin in wrong mode");
   chk_fast_freq: assert property (PLL_EN && $stable(PLL_EN)
      && $stable(PLL_REF_HALF) |->
      FAST_CLK_MHZ == (PLL_REF_HALF ? 7'd32 : 7'd64))
      else $error("fast clock frequency wrong");
   chk_gates_joint: assert property ($rose(CORE_CLK_EN) && !$past(IO_CLK_EN)
      |-> IO_CLK_EN && CONV_CLK_EN)
      else $error("clocks not released together");
   chk_ext_wake: assert property ((!(&EXT_INT_N)) [*4] |-> EXT_INT_WAKE)
      else $error("external interrupt not seen");
endmodule
bind csp_clock_ctrl csp_clock_ctrl_assertions #(.EXT_INTS(EXT_INTS)) u_chk (
   .CLK(CLK), .RESET_N(RESET_N), .FUSE_CLK_SEL(FUSE_CLK_SEL),
   .EXT_INT_N(EXT_INT_N), .CORE_CLK_EN(CORE_CLK_EN), .IO_CLK_EN(IO_CLK_EN),
   .FLASH_CLK_EN(FLASH_CLK_EN), .CONV_CLK_EN(CONV_CLK_EN), .PLL_EN(PLL_EN),
   .PLL_REF_HALF(PLL_REF_HALF), .PLL_LOCKED(PLL_LOCKED), .SYS_SRC(SYS_SRC),
   .SYS_PLL_DIV4(SYS_PLL_DIV4), .PB4_CLK_IN_SEL(PB4_CLK_IN_SEL),
   .PB5_XTAL_OUT_SEL(PB5_XTAL_OUT_SEL), .FAST_CLK_MHZ(FAST_CLK_MHZ),
   .EXT_INT_WAKE(EXT_INT_WAKE));
`default_nettype wire

// ===== tb/csp_osc_model.sv
/* csp_osc_model.sv: source and watchdog oscillators, behavioural PLL lock.
   Assumes it counts ticks for the bench since the last reset. */
`timescale 1ns/100ps
`default_nettype none
module csp_osc_model (
   input  wire logic reset_n,
   input  wire logic pll_en,
   output logic      src_clk,
   output logic      wdt_clk,
   output logic      pll_lock,
   output int        n_src,
   output int        n_wdt
);
   // Fixed period: no drift between cycles
   initial begin
      src_clk = 1'b0;
      forever #60 src_clk = ~src_clk;
   end
   initial begin
      wdt_clk = 1'b0;
      #37;
      forever #200 wdt_clk = ~wdt_clk;
   end
   initial pll_lock = 1'b0;
   // Lock needs settling time; losing enable drops it at once
   always @(posedge pll_en) begin
      #400;
      pll_lock = pll_en;
   end
   always @(negedge pll_en) pll_lock = 1'b0;
   always @(posedge src_clk or negedge reset_n)
      if (!reset_n) n_src <= 0;
      else n_src <= n_src + 1;
   always @(posedge wdt_clk or negedge reset_n)
      if (!reset_n) n_wdt <= 0;
      else n_wdt <= n_wdt + 1;
endmodule
`default_nettype wire

// ===== tb/csp_clock_ctrl_tb.sv
/* csp_clock_ctrl_tb.sv: self-checking bench for the clock control block.
   Assumes the oscillator model and shortened start-up counts. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin \
   n_errors++; $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module csp_clock_ctrl_tb;
   logic       clk, reset_n, wr_stb, rd_stb, sleep_cmd, wake_req;
   logic [2:0] addr, sys_src;
   logic [7:0] wr_data, rd_data, trim;
   logic [3:0] fuse_sel;
   logic [1:0] fuse_sut, ext_int_n, xrange;
   logic       src_clk, wdt_clk, pll_lock, core_en, io_en, flash_en;
   logic       conv_en, rc_en, pll_en, half, locked, div4, t1_fast;
   logic       pb4, pb5, ext_wake;
   logic [6:0] fast_mhz;
   int         n_src, n_wdt, n_errors, samples_checked;
   csp_clock_ctrl #(.WD_SHORT(14'd4), .WD_LONG(14'd8), .CK_1K(17'd6),
      .CK_16K(17'd10), .CK_32K(17'd12)) uut (
      .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WR_DATA(wr_data),
      .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data),
      .FUSE_CLK_SEL(fuse_sel), .FUSE_STARTUP(fuse_sut),
      .SRC_CLK_IN(src_clk), .WDT_OSC_IN(wdt_clk), .PLL_LOCK_IN(pll_lock),
      .EXT_INT_N(ext_int_n), .SLEEP_CMD(sleep_cmd), .WAKE_REQ(wake_req),
      .CORE_CLK_EN(core_en), .IO_CLK_EN(io_en), .FLASH_CLK_EN(flash_en),
      .CONV_CLK_EN(conv_en), .RC_OSC_EN(rc_en), .PLL_EN(pll_en),
      .PLL_REF_HALF(half), .PLL_LOCKED(locked), .SYS_SRC(sys_src),
      .XTAL_RANGE(xrange), .SYS_PLL_DIV4(div4), .T1_FAST_CLK_SEL(t1_fast),
      .PB4_CLK_IN_SEL(pb4), .PB5_XTAL_OUT_SEL(pb5), .OSC_TRIM(trim),
      .FAST_CLK_MHZ(fast_mhz), .EXT_INT_WAKE(ext_wake));
   csp_osc_model osc (.reset_n(reset_n), .pll_en(pll_en), .src_clk(src_clk),
      .wdt_clk(wdt_clk), .pll_lock(pll_lock), .n_src(n_src), .n_wdt(n_wdt));
   task automatic give_verdict;
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wait_core;
      int i;
      for (i = 0; i < 3000 && core_en !== 1'b1; i++) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e,
                     input string nm);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 `CHK(nm, e, rd_data)
   endtask
   // Fuses move only while reset is held
   task automatic boot(input logic [3:0] f, input logic [1:0] s);
      @(posedge clk);
      reset_n <= 1'b0;
      fuse_sel <= f;
      fuse_sut <= s;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      wait_core;
   endtask
   task automatic nap(input logic [7:0] m);
      wr(3'h2, m);
      sleep_cmd <= 1'b1;
      @(posedge clk);
      sleep_cmd <= 1'b0;
      #1;
   endtask
   task automatic wake_by_req;
      @(posedge clk) wake_req <= 1'b1;
      wait_core;
      @(posedge clk) wake_req <= 1'b0;
   endtask
   task automatic t_decode;
      logic [2:0] s;
      int f;
      for (f = 0; f < 16; f++) begin
         boot(f[3:0], 2'b00);
         s = (f < 4) ? f[2:0] : (f < 8) ? 3'h4 : 3'h5;
         `CHK("sys_src", s, sys_src)
         `CHK("pb4", (f == 0 || f > 3), pb4)
         `CHK("pb5", (f > 3), pb5)
         `CHK("div4", (f == 1), div4)
         `CHK("xtal_range", f[2:1], xrange)
         `CHK("gates", 4'hf, {core_en, flash_en, io_en, conv_en})
         rd(3'h3, {1'b0, s, ~f[3:0]}, "status");
      end
   endtask
   // Source phase spans about four watchdog ticks
   task automatic t_reset_time;
      int s, lo;
      for (s = 0; s < 4; s++) begin
         boot(4'h0, s[1:0]);
         lo = 4 + ((s == 0) ? 0 : (s == 1) ? 4 : 8);
         `CHK("n_src", 1'b1, n_src >= 14)
         `CHK("n_wdt_lo", 1'b1, n_wdt >= lo)
         `CHK("n_wdt_hi", 1'b1, n_wdt <= lo + 3)
      end
   endtask
   task automatic t_pll;
      boot(4'h1, 2'b00);
      `CHK("n_src_pll", 1'b1, n_src >= 20)
      `CHK("pll_en", 1'b1, pll_en)
      `CHK("fast_mhz", 7'd64, fast_mhz)
      tick(20);
      `CHK("locked", 1'b1, locked)
      rd(3'h0, 8'h03, "pllcs");
      wr(3'h0, 8'h82);
      tick(2);
      `CHK("half_pll", 1'b0, half)
      wr(3'h0, 8'h00);
      tick(3);
      `CHK("pll_off", 2'b00, {pll_en, locked})
      `CHK("fast_off", 7'd0, fast_mhz)
      boot(4'h2, 2'b00);
      wr(3'h0, 8'h82);
      tick(2);
      `CHK("half_rc", 2'b10, {half, pll_en})
   endtask
   task automatic t_regs;
      rd(3'h1, 8'h80, "trim_rst");
      wr(3'h1, 8'h7f);
      rd(3'h1, 8'h7f, "trim");
      @(posedge clk);
      #1 `CHK("rd_idle", 8'h00, rd_data)
      `CHK("osc_trim", 8'h7f, trim)
      wr(3'h5, 8'hff);
      rd(3'h5, 8'h00, "unmapped");
      rd(3'h1, 8'h7f, "trim_keep");
      rd(3'h4, 8'h00, "freq");
   endtask
   task automatic t_sleep;
      int snap;
      nap(8'h08);
      `CHK("t1_fast", 1'b1, t1_fast)
      `CHK("idle", 4'h3, {core_en, flash_en, io_en, conv_en})
      wake_by_req;
      nap(8'h09);
      `CHK("noise", 4'h1, {core_en, flash_en, io_en, conv_en})
      wake_by_req;
      `CHK("noise_wake", 4'hf, {core_en, flash_en, io_en, conv_en})
      nap(8'h0a);
      `CHK("pdown", 2'b00, {conv_en, rc_en})
      @(posedge clk) wake_req <= 1'b1;
      tick(6);
      `CHK("deep_refuse", 1'b0, core_en)
      snap = n_src;
      @(posedge clk) wake_req <= 1'b0;
      ext_int_n <= 2'b10;
      tick(4);
      `CHK("ext_wake", 1'b1, ext_wake)
      wait_core;
      `CHK("wake_ticks", 1'b1, n_src - snap >= 6)
      `CHK("rc_back", 1'b1, rc_en)
      `CHK("deep_wake", 4'hf, {core_en, flash_en, io_en, conv_en})
      @(posedge clk) ext_int_n <= 2'b11;
      nap(8'h0b);
      `CHK("psave", 5'h10, {rc_en, core_en, flash_en, io_en, conv_en})
      @(posedge clk) ext_int_n <= 2'b01;
      wait_core;
      `CHK("psave_wake", 4'hf, {core_en, flash_en, io_en, conv_en})
      @(posedge clk) ext_int_n <= 2'b11;
      nap(8'h0c);
      `CHK("standby", 5'h00, {rc_en, core_en, flash_en, io_en, conv_en})
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      reset_n = 1'b0;
      addr = 3'h0;
      wr_data = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      fuse_sel = 4'h2;
      fuse_sut = 2'b00;
      ext_int_n = 2'b11;
      sleep_cmd = 1'b0;
      wake_req = 1'b0;
      n_errors = 0;
      samples_checked = 0;
      t_decode;
      t_reset_time;
      t_pll;
      t_regs;
      t_sleep;
      give_verdict;
   end
   initial begin
      #2000000;
      n_errors++;
      give_verdict;
   end
endmodule
`default_nettype wire
